// *** core/gpio_pkg.sv ***
// Package for the three bit-programmable port block: offsets, reset values, mode codes.
// Assumes an 8-bit CPU register file with bank-0 byte addresses.
package gpio_pkg;
   localparam logic [7:0] ADDR_P0_UPPER_MODE = 8'h15;
   localparam logic [7:0] ADDR_P0_LOWER_MODE = 8'h16;
   localparam logic [7:0] ADDR_PULLUP_EN     = 8'h17;
   localparam logic [7:0] ADDR_P1_MODE       = 8'h18;
   localparam logic [7:0] ADDR_P2_UPPER_MODE = 8'h19;
   localparam logic [7:0] ADDR_P2_LOWER_MODE = 8'h1a;
   localparam logic [7:0] ADDR_PORT_ZERO     = 8'h1d;
   localparam logic [7:0] ADDR_PORT_ONE      = 8'h1e;
   localparam logic [7:0] ADDR_PORT_TWO      = 8'h1f;
   localparam logic [7:0] REG_RESET          = 8'h00;
   // Writable bit masks; other positions ignore writes and read zero
   localparam logic [7:0] MASK_P0_UPPER = 8'hee;
   localparam logic [7:0] MASK_PULLUP   = 8'hbf;
   localparam logic [7:0] MASK_P0_DATA  = 8'h3f;
   localparam logic [7:0] MASK_P1_DATA  = 8'h07;
   localparam logic [7:0] MASK_FULL     = 8'hff;
   // Field positions
   localparam int PIN5_FIELD_LSB = 6;
   localparam int PIN5_PD_BIT    = 5;
   localparam int PIN4_FIELD_LSB = 2;
   localparam int PIN4_PD_BIT    = 1;
   localparam int TCLK_FIELD_LSB = 6;
   localparam int TOUT_FIELD_LSB = 3;
   localparam int PWM_FIELD_LSB  = 0;
   localparam int P12_PULLUP_BIT = 7;
   // Two-bit mode codes
   localparam logic [1:0] M2_INPUT = 2'h0;
   localparam logic [1:0] M2_OD    = 2'h1;
   localparam logic [1:0] M2_ALT   = 2'h2;
   localparam logic [1:0] M2_PP    = 2'h3;
   // Port 2 codes
   localparam logic [1:0] P2_IN_PU = 2'h0;
   localparam logic [1:0] P2_IN    = 2'h1;
   localparam logic [1:0] P2H_OD   = 2'h2;
   localparam logic [1:0] P2L_ALT  = 2'h2;
   localparam logic [1:0] P2_PP    = 2'h3;
   // Three-bit codes for port 1 pins 1 and 0
   localparam logic [2:0] M3_IN    = 3'h0;
   localparam logic [2:0] M3_IN_PU = 3'h1;
   localparam logic [2:0] M3_PP    = 3'h4;
   localparam logic [2:0] M3_OD    = 3'h5;
   // Oscillator options
   localparam logic [2:0] OSC_CRYSTAL = 3'h7;
   localparam logic [2:0] OSC_RC_LO   = 3'h1;
   localparam logic [2:0] OSC_RC_HI   = 3'h4;
endpackage : gpio_pkg

// *** core/bit_programmable_io_ports.sv ***
// Three bit-programmable ports (6, 3 and 8 pins) with mode, pull and data registers.
// Assumes a CPU register port with address, write strobe and write/read data, asynchronous pins.
`timescale 1ns/1ps
module bit_programmable_io_ports
   import gpio_pkg::*;
#(
   parameter int P0_PINS = 6,
   parameter int P1_PINS = 3,
   parameter int P2_PINS = 8
)(
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic [7:0]           reg_addr,
   input  wire logic                 reg_wr,
   input  wire logic [7:0]           reg_wdata,
   output logic      [7:0]           reg_rdata,
   input  wire logic [2:0]           oscillator_option_select,
   input  wire logic [P0_PINS-1:0]   p0_in,
   output logic      [P0_PINS-1:0]   p0_out,
   output logic      [P0_PINS-1:0]   p0_oe,
   output logic      [P0_PINS-1:0]   p0_pullup,
   output logic      [1:0]           p0_pulldown,
   output logic      [3:0]           p0_analog_sel,
   output logic                      osc_pins_crystal,
   input  wire logic [P1_PINS-1:0]   p1_in,
   output logic      [P1_PINS-1:0]   p1_out,
   output logic      [P1_PINS-1:0]   p1_oe,
   output logic      [P1_PINS-1:0]   p1_pullup,
   output logic      [P1_PINS-1:0]   p1_analog_sel,
   input  wire logic                 timer_toggle_out,
   input  wire logic                 pwm_out,
   output logic                      timer_external_clock_in,
   input  wire logic [P2_PINS-1:0]   p2_in,
   output logic      [P2_PINS-1:0]   p2_out,
   output logic      [P2_PINS-1:0]   p2_oe,
   output logic      [P2_PINS-1:0]   p2_pullup,
   output logic      [3:0]           p2_analog_sel,
   output logic                      ext_irq_line_0,
   output logic                      ext_irq_line_1,
   output logic                      ext_irq_line_2,
   output logic                      ext_irq_line_3
);

   // Register layout fixes the pin counts; refuse anything else at elaboration
   if (P0_PINS != 6 || P1_PINS != 3 || P2_PINS != 8)
   begin : g_bad_widths
      $error("Port widths are fixed by the register layout");
   end

   // ********************************************************************
   // Registers
   // ********************************************************************
   logic [7:0] p0_upper_mode_reg;
   logic [7:0] p0_lower_mode_reg;
   logic [7:0] pullup_en_reg;
   logic [7:0] p1_mode_reg;
   logic [7:0] p2_upper_mode_reg;
   logic [7:0] p2_lower_mode_reg;
   logic [7:0] p0_data_reg;
   logic [7:0] p1_data_reg;
   logic [7:0] p2_data_reg;

   // Masked at write so unused bits can never become set
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         p0_upper_mode_reg <= REG_RESET;
         p0_lower_mode_reg <= REG_RESET;
         pullup_en_reg     <= REG_RESET;
         p1_mode_reg       <= REG_RESET;
         p2_upper_mode_reg <= REG_RESET;
         p2_lower_mode_reg <= REG_RESET;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            ADDR_P0_UPPER_MODE: p0_upper_mode_reg <= reg_wdata & MASK_P0_UPPER;
            ADDR_P0_LOWER_MODE: p0_lower_mode_reg <= reg_wdata;
            ADDR_PULLUP_EN:     pullup_en_reg     <= reg_wdata & MASK_PULLUP;
            ADDR_P1_MODE:       p1_mode_reg       <= reg_wdata;
            ADDR_P2_UPPER_MODE: p2_upper_mode_reg <= reg_wdata;
            ADDR_P2_LOWER_MODE: p2_lower_mode_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Output latches, written with plain stores
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         p0_data_reg <= REG_RESET;
         p1_data_reg <= REG_RESET;
         p2_data_reg <= REG_RESET;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            ADDR_PORT_ZERO: p0_data_reg <= reg_wdata & MASK_P0_DATA;
            ADDR_PORT_ONE:  p1_data_reg <= reg_wdata & MASK_P1_DATA;
            ADDR_PORT_TWO:  p2_data_reg <= reg_wdata & MASK_FULL;
            default: ;
         endcase
      end
   end

   // Input synchronisers; first stage feeds only the second
   logic [P0_PINS-1:0] p0_meta_reg, p0_sync_reg;
   logic [P1_PINS-1:0] p1_meta_reg, p1_sync_reg;
   logic [P2_PINS-1:0] p2_meta_reg, p2_sync_reg;
   always_ff @(posedge sys_clk)
   begin
      p0_meta_reg <= p0_in;
      p0_sync_reg <= p0_meta_reg;
      p1_meta_reg <= p1_in;
      p1_sync_reg <= p1_meta_reg;
      p2_meta_reg <= p2_in;
      p2_sync_reg <= p2_meta_reg;
   end

   // ********************************************************************
   // Mode decode
   // ********************************************************************
   logic [P0_PINS-1:0] p0_pp, p0_od, p0_alt, p0_is_out;
   logic [P1_PINS-1:0] p1_pp, p1_od, p1_alt, p1_is_out, p1_drive;
   logic [P2_PINS-1:0] p2_pp, p2_od, p2_pu_mode, p2_is_out;
   logic               gpio_osc_ok;
   logic [1:0]         p0_hi_field [2];
   logic [2:0]         p1_field3 [2];

   assign p0_hi_field[0] = p0_upper_mode_reg[PIN4_FIELD_LSB +: 2];
   assign p0_hi_field[1] = p0_upper_mode_reg[PIN5_FIELD_LSB +: 2];
   assign p1_field3[0]   = p1_mode_reg[PWM_FIELD_LSB +: 3];
   assign p1_field3[1]   = p1_mode_reg[TOUT_FIELD_LSB +: 3];

   // Crystal option takes the pins; only the RC options free them for I/O
   assign osc_pins_crystal = (oscillator_option_select == OSC_CRYSTAL);
   assign gpio_osc_ok = (oscillator_option_select >= OSC_RC_LO)
                        && (oscillator_option_select <= OSC_RC_HI);

   genvar i;
   generate
      for (i = 0; i < 4; i++)
      begin : g_p0_low
         logic [1:0] f;
         assign f = p0_lower_mode_reg[2*i +: 2];
         assign p0_pp[i]  = (f == M2_PP);
         assign p0_od[i]  = (f == M2_OD);
         assign p0_alt[i] = (f == M2_ALT);
      end
      for (i = 0; i < 2; i++)
      begin : g_p0_high
         // Code 10 is unavailable and behaves as input
         assign p0_pp[4+i]  = gpio_osc_ok && (p0_hi_field[i] == M2_PP);
         assign p0_od[4+i]  = gpio_osc_ok && (p0_hi_field[i] == M2_OD);
         assign p0_alt[4+i] = osc_pins_crystal;
      end
      for (i = 0; i < 2; i++)
      begin : g_p1_low
         assign p1_pp[i]  = (p1_field3[i] == M3_PP);
         assign p1_od[i]  = (p1_field3[i] == M3_OD);
         assign p1_alt[i] = (p1_field3[i][1] == 1'b1);
      end
      for (i = 0; i < P2_PINS; i++)
      begin : g_p2
         logic [1:0] f;
         assign f = (i < 4) ? p2_lower_mode_reg[2*(i%4) +: 2]
                            : p2_upper_mode_reg[2*(i%4) +: 2];
         assign p2_pp[i] = (f == P2_PP);
         assign p2_od[i] = (i >= 4) && (f == P2H_OD);
         assign p2_pu_mode[i] = (f == P2_IN_PU);
         assign p2_is_out[i] = p2_pp[i] || p2_od[i];
      end
   endgenerate

   assign p1_pp[2]  = (p1_mode_reg[TCLK_FIELD_LSB +: 2] == M2_PP);
   assign p1_od[2]  = (p1_mode_reg[TCLK_FIELD_LSB +: 2] == M2_OD);
   assign p1_alt[2] = (p1_mode_reg[TCLK_FIELD_LSB +: 2] == M2_ALT);
   assign p0_is_out = p0_pp | p0_od;
   assign p1_is_out = p1_pp | p1_od;

   // ********************************************************************
   // Pad control
   // ********************************************************************
   always_comb
   begin
      p0_out = '0;
      p0_oe  = '0;
      for (int k = 0; k < P0_PINS; k++)
      begin
         p0_oe[k] = p0_pp[k] || (p0_od[k] && !p0_data_reg[k]);
         p0_out[k] = p0_pp[k] ? p0_data_reg[k] : 1'b0;
      end
   end

   // Timer and PWM outputs take the pad in the 11x codes
   assign p1_drive[0] = (p1_field3[0][2:1] == 2'b11) ? pwm_out : p1_data_reg[0];
   assign p1_drive[1] = (p1_field3[1][2:1] == 2'b11) ? timer_toggle_out : p1_data_reg[1];
   assign p1_drive[2] = p1_data_reg[2];
   always_comb
   begin
      p1_out = '0;
      p1_oe  = '0;
      for (int k = 0; k < P1_PINS; k++)
      begin
         p1_oe[k] = p1_pp[k] || (p1_od[k] && !p1_data_reg[k])
                    || (k < 2 && p1_field3[k % 2][2:1] == 2'b11);
         p1_out[k] = (p1_od[k]) ? 1'b0 : p1_drive[k];
      end
   end

   always_comb
   begin
      p2_out = '0;
      p2_oe  = '0;
      for (int k = 0; k < P2_PINS; k++)
      begin
         p2_oe[k] = p2_pp[k] || (p2_od[k] && !p2_data_reg[k]);
         p2_out[k] = p2_pp[k] ? p2_data_reg[k] : 1'b0;
      end
   end

   // Port 0 and port 1 pin 2 drop pull-ups when push-pull or serving a peripheral, open-drain keeps them; other pins pull up only in the pull-up input code
   assign p0_pullup = pullup_en_reg[P0_PINS-1:0] & ~p0_pp & ~p0_alt;
   assign p1_pullup[0] = (p1_field3[0] == M3_IN_PU);
   assign p1_pullup[1] = (p1_field3[1] == M3_IN_PU);
   assign p1_pullup[2] = pullup_en_reg[P12_PULLUP_BIT] && !p1_pp[2] && !p1_alt[2];
   assign p2_pullup = p2_pu_mode;
   assign p0_pulldown[1] = p0_upper_mode_reg[PIN5_PD_BIT] && !p0_alt[5];
   assign p0_pulldown[0] = p0_upper_mode_reg[PIN4_PD_BIT] && !p0_alt[4];
   assign p0_analog_sel = p0_alt[3:0];
   assign p1_analog_sel = {p1_alt[2], p1_field3[1][2:1] == 2'b01,
                           p1_field3[0][2:1] == 2'b01};
   always_comb
   begin
      p2_analog_sel = '0;
      for (int k = 0; k < 4; k++)
         p2_analog_sel[k] = (p2_lower_mode_reg[2*k +: 2] == P2L_ALT);
   end

   // Peripheral inputs see the synchronised pad levels
   assign timer_external_clock_in = p1_sync_reg[2];
   assign ext_irq_line_0 = p2_sync_reg[0];
   assign ext_irq_line_1 = p2_sync_reg[1];
   assign ext_irq_line_2 = p2_sync_reg[2];
   assign ext_irq_line_3 = p2_sync_reg[3];

   // ********************************************************************
   // Read path
   // ********************************************************************
   logic [7:0] p0_rd, p1_rd, p2_rd;
   // Push-pull and open-drain pins read back the latch, all other pins (timer/PWM 11x included) the synced level
   assign p0_rd = {2'b00, (p0_is_out & p0_data_reg[P0_PINS-1:0])
                        | (~p0_is_out & p0_sync_reg)};
   assign p1_rd = {5'b00000, (p1_is_out & p1_data_reg[P1_PINS-1:0])
                           | (~p1_is_out & p1_sync_reg)};
   assign p2_rd = (p2_is_out & p2_data_reg) | (~p2_is_out & p2_sync_reg);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         reg_rdata <= REG_RESET;
      else
      begin
         unique case (reg_addr)
            ADDR_P0_UPPER_MODE: reg_rdata <= p0_upper_mode_reg;
            ADDR_P0_LOWER_MODE: reg_rdata <= p0_lower_mode_reg;
            ADDR_PULLUP_EN:     reg_rdata <= pullup_en_reg;
            ADDR_P1_MODE:       reg_rdata <= p1_mode_reg;
            ADDR_P2_UPPER_MODE: reg_rdata <= p2_upper_mode_reg;
            ADDR_P2_LOWER_MODE: reg_rdata <= p2_lower_mode_reg;
            ADDR_PORT_ZERO:     reg_rdata <= p0_rd;
            ADDR_PORT_ONE:      reg_rdata <= p1_rd;
            ADDR_PORT_TWO:      reg_rdata <= p2_rd;
            default:            reg_rdata <= REG_RESET;
         endcase
      end
   end

   // ********************************************************************
   // Checks
   // ********************************************************************
   a_data_reset: assert property (@(posedge sys_clk) rst |=> p0_data_reg == 8'h00
      && p1_data_reg == 8'h00 && p2_data_reg == 8'h00)
      else $error("Data registers not cleared by reset");
   a_mode_reset: assert property (@(posedge sys_clk) rst |=> p0_upper_mode_reg == 8'h00
      && p1_mode_reg == 8'h00 && p0_pulldown == 2'b00)
      else $error("Mode registers not cleared by reset");
   a_unused_zero: assert property (@(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == ADDR_PULLUP_EN |=> !pullup_en_reg[6])
      else $error("Unused pull-up bit stored a one");
   a_od_drive: assert property (@(posedge sys_clk) disable iff (rst)
      p2_od[7] && !p2_data_reg[7] |-> p2_oe[7] && !p2_out[7])
      else $error("Open-drain pin not pulled low");
   a_od_release: assert property (@(posedge sys_clk) disable iff (rst)
      p0_od[0] && p0_data_reg[0] |-> !p0_oe[0])
      else $error("Open-drain pin not released");
   a_pullup_gate: assert property (@(posedge sys_clk) disable iff (rst)
      p0_pp[2] || p0_alt[2] |-> !p0_pullup[2])
      else $error("Pull-up left on a driving pin");
   a_data_write: assert property (@(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == ADDR_PORT_TWO |=> p2_data_reg == $past(reg_wdata))
      else $error("Port two latch missed a write");
   a_read_input: assert property (@(posedge sys_clk) disable iff (rst)
      !reg_wr && reg_addr == ADDR_PORT_TWO && p2_upper_mode_reg == 8'h00
      ##1 reg_addr == ADDR_PORT_TWO |-> reg_rdata[7:4] == $past(p2_sync_reg[7:4]))
      else $error("Input read does not match pin level");
   a_osc_pins: assert property (@(posedge sys_clk) disable iff (rst)
      osc_pins_crystal |-> !p0_oe[5] && !p0_oe[4])
      else $error("Crystal pins driven as I/O");
endmodule : bit_programmable_io_ports

// *** sim/board_model.sv ***
// Board model: pad levels around the port block plus the timer and PWM outputs.
// Assumes the bench supplies external levels and enables; a driven pad always wins.
`timescale 1ns/1ps
module board_model (
   input  wire logic        sys_clk,
   input  wire logic [16:0] pin_out,
   input  wire logic [16:0] pin_oe,
   input  wire logic [16:0] pin_pu,
   input  wire logic [1:0]  p0_pd,
   input  wire logic [16:0] ext_val,
   input  wire logic [16:0] ext_en,
   output logic      [16:0] pin_lvl,
   output logic             timer_toggle_out,
   output logic             pwm_out
);
   // ************************************************************
   // Pad resolution
   // ************************************************************
   logic [16:0] last_lvl;
   logic [16:0] pd_vec;
   assign pd_vec = {11'h000, p0_pd, 4'h0};
   // A pad with neither driver nor pull keeps changing, so a stale level never passes
   always_comb
   begin
      for (int i = 0; i < 17; i++)
      begin
         if (pin_oe[i])
            pin_lvl[i] = pin_out[i];
         else if (ext_en[i])
            pin_lvl[i] = ext_val[i];
         else if (pin_pu[i])
            pin_lvl[i] = 1'b1;
         else if (pd_vec[i])
            pin_lvl[i] = 1'b0;
         else
            pin_lvl[i] = ~last_lvl[i];
      end
   end
   always @(posedge sys_clk)
      last_lvl <= pin_lvl;
   // ************************************************************
   // Peripheral outputs, free running as if already enabled
   // ************************************************************
   initial
   begin
      last_lvl = 17'h00000;
      timer_toggle_out = 1'b0;
      pwm_out = 1'b0;
   end
   always @(posedge sys_clk)
   begin
      pwm_out <= ~pwm_out;
      timer_toggle_out <= pwm_out;
   end
endmodule : board_model

// *** sim/testbench.sv ***
// Self-checking bench for the three-port block: register model, pin and mode checks.
// Assumes the board model closes the pad loop and raises the peripheral outputs.
`timescale 1ns/1ps
module testbench;
   logic        sys_clk;
   logic        rst;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic        reg_wr;
   logic [2:0]  osc_sel;
   logic [5:0]  p0_out, p0_oe, p0_pullup;
   logic [1:0]  p0_pulldown;
   logic [3:0]  p0_analog_sel, p2_analog_sel, irq_lines;
   logic [2:0]  p1_out, p1_oe, p1_pullup, p1_analog_sel;
   logic [7:0]  p2_out, p2_oe, p2_pullup;
   logic        osc_pins_crystal, timer_toggle_out, pwm_out, tclk_in;
   logic [16:0] pin_lvl, ext_val, ext_en;
   logic [15:0] lfsr_reg;
   logic [7:0]  ref_regs [logic [7:0]];
   logic [7:0]  d [3];
   logic [7:0]  mode_addr [7] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b};
   int          errors, num_checks;

   bit_programmable_io_ports bit_programmable_io_ports_i (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .oscillator_option_select(osc_sel),
      .p0_in(pin_lvl[5:0]), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pullup(p0_pullup),
      .p0_pulldown(p0_pulldown), .p0_analog_sel(p0_analog_sel),
      .osc_pins_crystal(osc_pins_crystal), .p1_in(pin_lvl[8:6]), .p1_out(p1_out),
      .p1_oe(p1_oe), .p1_pullup(p1_pullup), .p1_analog_sel(p1_analog_sel),
      .timer_toggle_out(timer_toggle_out), .pwm_out(pwm_out),
      .timer_external_clock_in(tclk_in), .p2_in(pin_lvl[16:9]), .p2_out(p2_out),
      .p2_oe(p2_oe), .p2_pullup(p2_pullup), .p2_analog_sel(p2_analog_sel),
      .ext_irq_line_0(irq_lines[0]), .ext_irq_line_1(irq_lines[1]),
      .ext_irq_line_2(irq_lines[2]), .ext_irq_line_3(irq_lines[3])
   );
   board_model board_model_i (
      .sys_clk(sys_clk), .pin_out({p2_out, p1_out, p0_out}), .pin_oe({p2_oe, p1_oe, p0_oe}),
      .pin_pu({p2_pullup, p1_pullup, p0_pullup}), .p0_pd(p0_pulldown), .ext_val(ext_val),
      .ext_en(ext_en), .pin_lvl(pin_lvl), .timer_toggle_out(timer_toggle_out),
      .pwm_out(pwm_out)
   );

   // ************************************************************
   // Helpers
   // ************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   function automatic logic [7:0] next_rand();
      lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      return lfsr_reg[7:0];
   endfunction : next_rand
   // Writable bits per address; unmapped places keep nothing
   function automatic logic [7:0] mask_of(input logic [7:0] a);
      case (a)
         8'h15: return 8'hee;
         8'h17: return 8'hbf;
         8'h1d: return 8'h3f;
         8'h1e: return 8'h07;
         8'h16, 8'h18, 8'h19, 8'h1a, 8'h1f: return 8'hff;
         default: return 8'h00;
      endcase
   endfunction : mask_of
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Strobe dropped a full cycle before returning, so back-to-back calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] val);
      reg_addr <= a;
      reg_wdata <= val;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      ref_regs[a] = val & mask_of(a);
      @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr <= a;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(reg_rdata, exp);
      @(posedge sys_clk);
   endtask : rd
   task automatic cfg(input logic [7:0] v [6]);
      for (int i = 0; i < 6; i++)
         wr(8'h15 + 8'(i), v[i]);
   endtask : cfg
   task automatic data_round();
      for (int i = 0; i < 3; i++)
      begin
         d[i] = next_rand();
         wr(8'h1d + 8'(i), d[i]);
      end
   endtask : data_round
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial
   begin
      errors = 0;
      num_checks = 0;
      lfsr_reg = 16'h01d7;
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      osc_sel = 3'h1;
      ext_val = 17'h00000;
      ext_en = 17'h1ffff;
      repeat (4) @(posedge sys_clk);
      chk(p2_pullup, 8'hff);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (int a = 8'h14; a < 8'h20; a++)
         rd(8'(a), 8'h00);
      foreach (mode_addr[i])
         for (int k = 0; k < 3; k++)
         begin
            wr(mode_addr[i], (k == 0) ? 8'hff : next_rand());
            rd(mode_addr[i], ref_regs[mode_addr[i]]);
         end
      // All push-pull: latches show, pull-ups fall away
      cfg('{8'hcc, 8'hff, 8'hff, 8'he4, 8'hff, 8'hff});
      for (int i = 0; i < 3; i++)
         rd(8'h1d + 8'(i), 8'h00);
      repeat (4)
      begin
         data_round();
         chk({p2_out, p1_out, p0_out}, {d[2], d[1][2:0], d[0][5:0]});
         chk({p2_oe, p1_oe, p0_oe}, 17'h1ffff);
         chk({p1_pullup, p0_pullup}, 9'h000);
         rd(8'h1d, d[0] & 8'h3f);
      end
      // Open-drain where offered; pads left to pulls and floats
      ext_en <= 17'h00000;
      cfg('{8'h44, 8'h55, 8'hff, 8'h6d, 8'haa, 8'h55});
      repeat (4)
      begin
         data_round();
         chk({p2_oe, p1_oe, p0_oe}, {~d[2][7:4], 4'h0, ~d[1][2:0], ~d[0][5:0]});
         chk({p1_pullup, p0_pullup}, 9'h13f);
         rd(8'h1e, {5'h00, d[1][2:0]});
      end
      // Inputs with pulls; pad levels read back and routed to peripherals
      cfg('{8'h22, 8'h00, 8'hff, 8'h09, 8'h00, 8'h00});
      chk({p2_pullup, p1_pullup, p0_pullup}, {8'hff, 3'h7, 6'h3f});
      chk(p0_pulldown, 2'h3);
      ext_en <= 17'h1ffff;
      repeat (4)
      begin
         ext_val <= 17'({next_rand(), next_rand(), next_rand()});
         repeat (3) @(posedge sys_clk);
         rd(8'h1d, {2'h0, ext_val[5:0]});
         rd(8'h1e, {5'h00, ext_val[8:6]});
         rd(8'h1f, ext_val[16:9]);
         chk({irq_lines, tclk_in}, ext_val[12:8]);
      end
      // Analog and timer functions
      cfg('{8'h00, 8'haa, 8'hff, 8'h92, 8'h00, 8'haa});
      chk({p2_analog_sel, p1_analog_sel, p0_analog_sel}, 11'h7ff);
      chk({p2_pullup, p1_pullup, p0_pullup}, 17'h1e030);
      for (int c = 6; c < 8; c++)
      begin
         wr(8'h18, {2'h0, 3'(c), 3'(c)});
         repeat (3)
         begin
            @(negedge sys_clk);
            chk({p1_oe[1:0], p1_out[1:0]}, {2'h3, timer_toggle_out, pwm_out});
         end
      end
      // Oscillator option decides whether pins 5 and 4 may drive
      wr(8'h15, 8'hcc);
      wr(8'h1d, 8'h30);
      for (int o = 0; o < 8; o++)
      begin
         osc_sel <= 3'(o);
         repeat (2) @(posedge sys_clk);
         chk({osc_pins_crystal, p0_oe[5:4]}, {o == 7, (o >= 1 && o <= 4) ? 2'h3 : 2'h0});
      end
      osc_sel <= 3'h1;
      wr(8'h15, 8'h88);
      chk(p0_oe[5:4], 2'h0);
      give_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      give_verdict();
   end
endmodule : testbench
